// *** etac_accum.v ***
// Purpose: sums adjusted entries of one instruction stream with head/tail overlap
// Assumes: one entry at most per clock, first entry flagged
// Notes: a single part may be negative when a head exceeds its own count
`timescale 1ns/1ns
`include "etac_defines.vh"

module etac_accum #(
  parameter AW = `ETAC_CALC_W,
  parameter TW = `ETAC_TOTAL_W
) (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // adjusted entry
  input wire ent_valid,
  input wire ent_first,
  input wire ent_last,
  input wire [AW-1:0] ent_head,
  input wire [AW-1:0] ent_tail,
  input wire [AW-1:0] ent_cc,
  // stream total
  output reg total_valid,
  output reg signed [TW-1:0] total_clocks
);

  function [AW-1:0] etac_min;
    input [AW-1:0] a;
    input [AW-1:0] b;
    begin
      etac_min = (a < b) ? a : b;
    end
  endfunction

  reg [AW-1:0] prev_tail_q;
  reg signed [TW-1:0] sum_q;
  reg signed [TW-1:0] part;
  reg signed [TW-1:0] base;

  // one stream part: own count less the overlap with the previous tail
  always @*
  begin
    part = $signed(ent_cc[TW-1:0]);
    if (!ent_first)
      part = $signed(ent_cc[TW-1:0]) - $signed(etac_min(ent_head, prev_tail_q));
    base = ent_first ? {TW{1'b0}} : sum_q;
  end

  // running sum; the previous tail is kept for the next overlap
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      prev_tail_q <= {AW{1'b0}};
      sum_q <= {TW{1'b0}};
      total_valid <= 1'b0;
      total_clocks <= {TW{1'b0}};
    end
    else
    begin
      total_valid <= 1'b0;
      if (ent_valid)
      begin
        sum_q <= base + part;
        prev_tail_q <= ent_tail;
        if (ent_last)
        begin
          total_valid <= 1'b1;
          total_clocks <= base + part;
        end
      end
    end
  end

endmodule

// *** etac_core.v ***
// Purpose: corrects listed tail and clock count for cache hits and wait states; head passes unchanged
// Assumes: entries come from logic on clk_sys; wait states fixed while a stream runs
// Notes: no-cache-case formula and multi-register move equations are not modelled
`timescale 1ns/1ns
`include "etac_defines.vh"

module etac_core #(
  parameter W = `ETAC_LIST_W,
  parameter NW = `ETAC_CNT_W,
  parameter SW = `ETAC_WS_W,
  parameter AW = `ETAC_CALC_W,
  parameter TW = `ETAC_TOTAL_W
) (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // listed entry
  input wire in_valid,
  input wire in_first,
  input wire in_last,
  input wire [`ETAC_KIND_W-1:0] in_kind,
  input wire in_mem_indirect,
  input wire [W-1:0] in_head,
  input wire [W-1:0] in_tail,
  input wire [W-1:0] in_cc,
  input wire [NW-1:0] in_reads,
  input wire [NW-1:0] in_writes,
  input wire in_dcache_hit,
  input wire in_locked_rmw,
  input wire in_read_folded,
  // system
  input wire [SW-1:0] wait_states,
  // adjusted entry
  output reg adj_valid,
  output reg [AW-1:0] adj_head,
  output reg [AW-1:0] adj_tail,
  output reg [AW-1:0] adj_cc,
  output reg [NW-1:0] adj_ext_reads,
  output reg [NW-1:0] adj_ext_writes,
  output reg adj_special,
  // stream total
  output wire total_valid,
  output wire signed [TW-1:0] total_clocks
);

  // wait clocks of n accesses; each wait state is one clock per access
  function [AW-1:0] etac_wmul;
    input [NW-1:0] n;
    input [SW-1:0] ws;
    integer i;
    reg [AW-1:0] acc;
    begin
      acc = {AW{1'b0}};
      for (i = 0; i < NW; i = i + 1)
        if (n[i])
          acc = acc + ({{(AW-SW){1'b0}}, ws} << i);
      etac_wmul = acc;
    end
  endfunction

  // widen a listed value to calculation width
  function [AW-1:0] etac_ext;
    input [W-1:0] v;
    begin
      etac_ext = {{(AW-W){1'b0}}, v};
    end
  endfunction

  // a usable data cache hit; locked cycles are forced to miss on every read
  function etac_hit_ok;
    input hit;
    input locked;
    begin
      etac_hit_ok = hit & ~locked;
    end
  endfunction

  // tail left after a cached address fetch: 0 stays, 1 drops to 0, more becomes 1
  function [AW-1:0] etac_hit_tail;
    input [AW-1:0] t;
    begin
      if (t == `ETAC_TAIL_ZERO)
        etac_hit_tail = t;
      else if (t == `ETAC_TAIL_ONE)
        etac_hit_tail = t - `ETAC_TAIL_ONE;
      else
        etac_hit_tail = `ETAC_TAIL_ONE;
    end
  endfunction

  // clocks saved by a cached address fetch; the count loses what the tail loses
  function [AW-1:0] etac_hit_cut;
    input [AW-1:0] t;
    begin
      if (t == `ETAC_TAIL_ZERO)
        etac_hit_cut = {AW{1'b0}};
      else if (t == `ETAC_TAIL_ONE)
        etac_hit_cut = `ETAC_TAIL_ONE;
      else
        etac_hit_cut = t - `ETAC_TAIL_ONE;
    end
  endfunction

  // captured entry
  reg v_q;
  reg first_q;
  reg last_q;
  reg [`ETAC_KIND_W-1:0] kind_q;
  reg mi_q;
  reg [W-1:0] head_q;
  reg [W-1:0] tail_q;
  reg [W-1:0] cc_q;
  reg [NW-1:0] reads_q;
  reg [NW-1:0] writes_q;
  reg hit_q;
  reg locked_q;
  reg folded_q;
  reg [SW-1:0] ws_q;

  // stream framing travels beside the adjusted entry
  reg first_adj_q;
  reg last_adj_q;

  // capture stage: inputs are on clk_sys already, so no synchroniser
  // wait states travel with every entry, so a change only reaches later entries
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      v_q <= 1'b0;
      first_q <= 1'b0;
      last_q <= 1'b0;
      kind_q <= `ETAC_KIND_FEA;
      mi_q <= 1'b0;
      head_q <= {W{1'b0}};
      tail_q <= {W{1'b0}};
      cc_q <= {W{1'b0}};
      reads_q <= {NW{1'b0}};
      writes_q <= {NW{1'b0}};
      hit_q <= 1'b0;
      locked_q <= 1'b0;
      folded_q <= 1'b0;
      ws_q <= {SW{1'b0}};
    end
    else
    begin
      v_q <= in_valid;
      first_q <= in_first;
      last_q <= in_last;
      kind_q <= in_kind;
      mi_q <= in_mem_indirect;
      head_q <= in_head;
      tail_q <= in_tail;
      cc_q <= in_cc;
      reads_q <= in_reads;
      writes_q <= in_writes;
      hit_q <= in_dcache_hit;
      locked_q <= in_locked_rmw;
      folded_q <= in_read_folded;
      ws_q <= wait_states;
    end
  end

  reg fea_hit;
  reg op_hit;
  reg cea_hit;
  reg has_reads;
  reg has_writes;
  reg [AW-1:0] ws_e;
  reg [AW-1:0] t_lst;
  reg [AW-1:0] h_d;
  reg [AW-1:0] t_d;
  reg [AW-1:0] c_d;
  reg [NW-1:0] er_d;
  reg [NW-1:0] ew_d;
  reg sp_d;

  // hit qualification; locked cycles are forced to miss
  always @*
  begin
    has_reads = (reads_q != {NW{1'b0}});
    has_writes = (writes_q != {NW{1'b0}});
    fea_hit = etac_hit_ok(hit_q, locked_q) & has_reads & (kind_q == `ETAC_KIND_FEA);
    // folded reads are charged as misses since their hit cannot be separated
    op_hit = etac_hit_ok(hit_q, locked_q) & ~folded_q & (kind_q == `ETAC_KIND_OP);
    // an indirect pointer read that hits needs neither a bus cycle nor waits
    cea_hit = etac_hit_ok(hit_q, locked_q) & has_reads & (kind_q == `ETAC_KIND_CEA);
  end

  // correction of one entry: cache first, then wait states
  always @*
  begin
    ws_e = {{(AW-SW){1'b0}}, ws_q};
    t_lst = etac_ext(tail_q);
    h_d = etac_ext(head_q);
    t_d = t_lst;
    c_d = etac_ext(cc_q);
    er_d = reads_q;
    ew_d = writes_q;
    sp_d = 1'b0;
    // cache hit on the address fetch; all its external reads are dropped, indirect or not
    if (fea_hit)
    begin
      er_d = {NW{1'b0}};
      t_d = etac_hit_tail(t_lst);
      c_d = c_d - etac_hit_cut(t_lst);
    end
    if (op_hit || cea_hit)
      er_d = {NW{1'b0}};
    case (kind_q)
      `ETAC_KIND_FEA:
      begin
        // a hit fetch gets no read waits at all
        if (has_reads && !fea_hit)
        begin
          if (mi_q)
          begin
            c_d = c_d + (ws_e << 1);
            t_d = t_d + ws_e;
          end
          else
          begin
            c_d = c_d + ws_e;
            t_d = t_d + ws_e;
          end
        end
      end
      `ETAC_KIND_CEA:
      begin
        // a cached pointer read adds no waits at all
        if (mi_q && has_reads && !cea_hit)
          c_d = c_d + ws_e;
      end
      `ETAC_KIND_OP:
      begin
        if (!op_hit)
          c_d = c_d + etac_wmul(reads_q, ws_q);
        // writes always wait, hit or not
        c_d = c_d + etac_wmul(writes_q, ws_q);
        if (has_writes)
          t_d = t_d + ws_e;
      end
      `ETAC_KIND_MOVE:
      begin
        // listed values pass unchanged; caller owns the special equations
        sp_d = 1'b1;
      end
      default:
      begin
        sp_d = 1'b0;
      end
    endcase
  end

  // adjusted entry register
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      adj_valid <= 1'b0;
      adj_head <= {AW{1'b0}};
      adj_tail <= {AW{1'b0}};
      adj_cc <= {AW{1'b0}};
      adj_ext_reads <= {NW{1'b0}};
      adj_ext_writes <= {NW{1'b0}};
      adj_special <= 1'b0;
      first_adj_q <= 1'b0;
      last_adj_q <= 1'b0;
    end
    else
    begin
      adj_valid <= v_q;
      first_adj_q <= v_q & first_q;
      last_adj_q <= v_q & last_q;
      // data outputs hold between pulses so a slow reader still sees the last entry
      if (v_q)
      begin
        adj_head <= h_d;
        adj_tail <= t_d;
        adj_cc <= c_d;
        adj_ext_reads <= er_d;
        adj_ext_writes <= ew_d;
        adj_special <= sp_d;
      end
    end
  end

  // stream total over the adjusted entries
  etac_accum #(
    .AW(AW),
    .TW(TW)
  ) u_accum (
    .clk_sys(clk_sys),
    .reset(reset),
    .ent_valid(adj_valid),
    .ent_first(first_adj_q),
    .ent_last(last_adj_q),
    .ent_head(adj_head),
    .ent_tail(adj_tail),
    .ent_cc(adj_cc),
    .total_valid(total_valid),
    .total_clocks(total_clocks)
  );

endmodule

// *** etac_core_sva.sv ***
// Purpose: port-level checks of the timing adjust core
// Assumes: an adjusted entry appears two edges after it is taken
// Notes: bound onto every etac_core instance
`timescale 1ns/1ns
`include "etac_defines.vh"
module etac_core_sva #(
  parameter W = 8,
  parameter NW = 4,
  parameter SW = 4,
  parameter AW = 16,
  parameter TW = 16
) (
  // clock and reset
  input logic clk_sys,
  input logic reset,
  // listed entry
  input logic in_valid,
  input logic in_first,
  input logic in_last,
  input logic [`ETAC_KIND_W-1:0] in_kind,
  input logic in_mem_indirect,
  input logic [W-1:0] in_head,
  input logic [W-1:0] in_tail,
  input logic [W-1:0] in_cc,
  input logic [NW-1:0] in_reads,
  input logic [NW-1:0] in_writes,
  input logic in_dcache_hit,
  input logic in_locked_rmw,
  input logic [SW-1:0] wait_states,
  // adjusted entry and total
  input logic adj_valid,
  input logic [AW-1:0] adj_head,
  input logic [AW-1:0] adj_tail,
  input logic [AW-1:0] adj_cc,
  input logic [NW-1:0] adj_ext_reads,
  input logic [NW-1:0] adj_ext_writes,
  input logic adj_special,
  input logic total_valid,
  input logic signed [TW-1:0] total_clocks
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // entry kinds that steer the corrections
  wire fea = in_valid && in_kind == `ETAC_KIND_FEA && in_reads != 0;
  wire fea_hit = fea && in_dcache_hit && !in_locked_rmw;
  wire op = in_valid && in_kind == `ETAC_KIND_OP;
  wire mv = in_valid && in_kind == `ETAC_KIND_MOVE;
  sequence s_one;
    in_valid && in_first && in_last ##2 adj_valid;
  endsequence
  property p_head;
    in_valid |-> ##2 adj_valid && adj_head == $past(in_head, 2);
  endproperty
  property p_rd;
    fea && !in_mem_indirect && !in_dcache_hit |-> ##2
      adj_tail == $past(in_tail, 2) + $past(wait_states, 2);
  endproperty
  property p_hit0;
    fea_hit && in_tail == 0 |-> ##2 adj_tail == 0 && adj_cc == $past(in_cc, 2);
  endproperty
  property p_nobus;
    fea_hit |-> ##2 adj_ext_reads == 0;
  endproperty
  property p_wr;
    in_valid && !mv |-> ##2 adj_ext_writes == $past(in_writes, 2);
  endproperty
  property p_optail;
    op && in_writes == 0 |-> ##2 adj_tail == $past(in_tail, 2);
  endproperty
  property p_wrtail;
    op && in_writes != 0 |-> ##2 adj_tail == $past(in_tail, 2) + $past(wait_states, 2);
  endproperty
  property p_move;
    mv |-> ##2 adj_special && adj_cc == $past(in_cc, 2);
  endproperty
  property p_cea;
    in_valid && in_kind == `ETAC_KIND_CEA && in_dcache_hit && !in_locked_rmw && in_reads != 0
      |-> ##2 adj_cc == $past(in_cc, 2) && adj_ext_reads == 0;
  endproperty
  // a one-entry stream totals to its own adjusted count
  property p_tot;
    s_one |=> total_valid && total_clocks == $signed($past(adj_cc));
  endproperty
  a_head: assert property (p_head) else $error("head changed");
  a_rd: assert property (p_rd) else $error("read tail wrong");
  a_hit0: assert property (p_hit0) else $error("zero tail hit changed");
  a_nobus: assert property (p_nobus) else $error("hit made a bus read");
  a_wr: assert property (p_wr) else $error("write cycles lost");
  a_optail: assert property (p_optail) else $error("read op tail moved");
  a_wrtail: assert property (p_wrtail) else $error("write op tail wrong");
  a_move: assert property (p_move) else $error("move not passed");
  a_tot: assert property (p_tot) else $error("single total wrong");
  a_cea: assert property (p_cea) else $error("cached pointer read waited");
endmodule
bind etac_core etac_core_sva #(.W(W), .NW(NW), .SW(SW), .AW(AW), .TW(TW)) u_sva (.*);

// *** etac_defines.vh ***
// Purpose: shared constants of the execution time adjust calculator
// Assumes: plain Verilog-2005, included by bare name
// Notes: entry kinds, calculation widths and tail constants
`ifndef ETAC_DEFINES_VH
`define ETAC_DEFINES_VH

// entry kinds
`define ETAC_KIND_W 2
`define ETAC_KIND_FEA 2'h0
`define ETAC_KIND_CEA 2'h1
`define ETAC_KIND_OP 2'h2
`define ETAC_KIND_MOVE 2'h3

// listed tail values that steer the cache correction
`define ETAC_TAIL_ZERO 16'h0000
`define ETAC_TAIL_ONE 16'h0001

// default widths
`define ETAC_LIST_W 8
`define ETAC_CNT_W 4
`define ETAC_WS_W 4
`define ETAC_CALC_W 16
`define ETAC_TOTAL_W 16

`endif

// *** etac_feed.sv ***
// Purpose: supplies listed timing entries to the core
// Assumes: one entry per call, taken at the edge after it is raised
// Notes: head, tail and count are scrambled once taken so stale values never match
`timescale 1ns/1ns
module etac_feed (
  // clock
  input logic clk_sys,
  // listed entry
  output logic valid,
  output logic [1:0] fl,
  output logic [1:0] kind,
  output logic mind,
  output logic [7:0] head,
  output logic [7:0] tail,
  output logic [7:0] cc,
  output logic [3:0] rd,
  output logic [3:0] wr,
  output logic [2:0] flags
);
  // idle until asked
  initial
  begin
    {valid, fl, kind, mind, head, tail, cc, rd, wr, flags} = '0;
  end
  // raise one entry, then drop it and invert head, tail and count
  task put(input logic [1:0] k, input logic m, input logic [7:0] h, t, c,
    input logic [3:0] r, w, input logic [2:0] f, input logic [1:0] s);
    @(posedge clk_sys);
    valid <= 1'b1;
    {kind, mind, head, tail, cc, rd, wr, flags, fl} <= {k, m, h, t, c, r, w, f, s};
    @(posedge clk_sys);
    valid <= 1'b0;
    {head, tail, cc} <= ~{h, t, c};
  endtask
endmodule

// *** tb_exec_time_adjust_calc.sv ***
// Purpose: self-checking bench of the timing adjust core
// Assumes: adjusted values two edges after an entry is taken
// Notes: expectations are worked out by hand per entry
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module tb_exec_time_adjust_calc;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] ws = 4'h0;
  logic v, mi;
  logic [1:0] fl, k;
  logic [2:0] fg;
  logic [7:0] h, t, c;
  logic [3:0] r, w, ext_r, ext_w;
  logic adj_valid, adj_special, total_valid;
  logic [15:0] adj_head, adj_tail, adj_cc;
  logic signed [15:0] total_clocks;
  int n_checks = 0;
  int n_mismatch = 0;
  // 10 mhz system clock
  always #50 clk_sys = ~clk_sys;
  etac_feed u_feed (.clk_sys(clk_sys), .valid(v), .fl(fl), .kind(k), .mind(mi), .head(h),
    .tail(t), .cc(c), .rd(r), .wr(w), .flags(fg));
  etac_core dut (.clk_sys(clk_sys), .reset(reset), .in_valid(v), .in_first(fl[1]),
    .in_last(fl[0]), .in_kind(k), .in_mem_indirect(mi), .in_head(h), .in_tail(t), .in_cc(c),
    .in_reads(r), .in_writes(w), .in_dcache_hit(fg[2]), .in_locked_rmw(fg[1]),
    .in_read_folded(fg[0]), .wait_states(ws), .adj_valid(adj_valid), .adj_head(adj_head),
    .adj_tail(adj_tail), .adj_cc(adj_cc), .adj_ext_reads(ext_r), .adj_ext_writes(ext_w),
    .adj_special(adj_special), .total_valid(total_valid), .total_clocks(total_clocks));
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait for an adjusted entry or a stream total
  task wt(input logic tot);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      #1;
      if ((tot ? total_valid : adj_valid) === 1'b1)
        return;
    end
    n_mismatch++;
    wrap_up();
  endtask
  // one-entry stream; rw holds reads then writes, fg is hit, locked, folded
  task run(input logic [1:0] kk, input logic m, input logic [7:0] tt, cc, rw,
    input logic [2:0] f, input logic [7:0] et, ec);
    u_feed.put(kk, m, 8'h03, tt, cc, rw[7:4], rw[3:0], f, 2'h3);
    wt(1'b0);
    `CHK(adj_head, 16'h0003);
    `CHK(adj_tail, {8'h00, et});
    `CHK(adj_cc, {8'h00, ec});
  endtask
  task t_hit;
    run(2'h0, 1'b0, 8'h02, 8'h04, 8'h10, 3'h4, 8'h01, 8'h03);
    run(2'h0, 1'b0, 8'h01, 8'h03, 8'h10, 3'h4, 8'h00, 8'h02);
    run(2'h0, 1'b0, 8'h05, 8'h09, 8'h10, 3'h4, 8'h01, 8'h05);
    run(2'h0, 1'b1, 8'h03, 8'h0c, 8'h20, 3'h4, 8'h01, 8'h0a);
    run(2'h0, 1'b1, 8'h00, 8'h0a, 8'h20, 3'h4, 8'h00, 8'h0a);
    `CHK(ext_r, 4'h0);
    $display("t_hit done");
  endtask
  task t_ws;
    @(posedge clk_sys);
    ws <= 4'h2;
    run(2'h0, 1'b0, 8'h00, 8'h06, 8'h10, 3'h0, 8'h02, 8'h08);
    run(2'h1, 1'b1, 8'h00, 8'h0c, 8'h10, 3'h0, 8'h00, 8'h0e);
    run(2'h0, 1'b1, 8'h00, 8'h0c, 8'h20, 3'h0, 8'h02, 8'h10);
    run(2'h2, 1'b0, 8'h00, 8'h0e, 8'h10, 3'h0, 8'h00, 8'h10);
    run(2'h2, 1'b0, 8'h00, 8'h0e, 8'h20, 3'h0, 8'h00, 8'h12);
    run(2'h2, 1'b0, 8'h01, 8'h03, 8'h01, 3'h0, 8'h03, 8'h05);
    run(2'h2, 1'b0, 8'h00, 8'h08, 8'h03, 3'h0, 8'h02, 8'h0e);
    $display("t_ws done");
  endtask
  task t_mix;
    run(2'h0, 1'b0, 8'h02, 8'h04, 8'h10, 3'h4, 8'h01, 8'h03);
    run(2'h2, 1'b0, 8'h01, 8'h03, 8'h11, 3'h4, 8'h03, 8'h05);
    `CHK(ext_w, 4'h1);
    `CHK(ext_r, 4'h0);
    run(2'h2, 1'b0, 8'h00, 8'h0c, 8'h10, 3'h6, 8'h00, 8'h0e);
    run(2'h0, 1'b0, 8'h02, 8'h04, 8'h10, 3'h6, 8'h04, 8'h06);
    `CHK(ext_r, 4'h1);
    run(2'h1, 1'b1, 8'h00, 8'h0c, 8'h10, 3'h4, 8'h00, 8'h0c);
    `CHK(ext_r, 4'h0);
    run(2'h2, 1'b0, 8'h00, 8'h0e, 8'h10, 3'h5, 8'h00, 8'h10);
    run(2'h3, 1'b0, 8'h00, 8'h18, 8'h40, 3'h0, 8'h00, 8'h18);
    `CHK(adj_special, 1'b1);
    $display("t_mix done");
  endtask
  // three entries: 4 + (3 - min(0,2)) + (4 - min(6,1)) = 10
  task t_sum;
    u_feed.put(2'h2, 1'b0, 8'h02, 8'h02, 8'h04, 4'h0, 4'h0, 3'h0, 2'h2);
    u_feed.put(2'h2, 1'b0, 8'h00, 8'h01, 8'h03, 4'h0, 4'h0, 3'h0, 2'h0);
    u_feed.put(2'h2, 1'b0, 8'h06, 8'h00, 8'h04, 4'h0, 4'h0, 3'h0, 2'h1);
    wt(1'b1);
    `CHK(total_clocks, 16'sh000a);
    $display("t_sum done");
  endtask
  // reset for four cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_hit();
    t_ws();
    t_mix();
    t_sum();
    wrap_up();
  end
endmodule
